// [pkg/mcr_cfg.svh]
// offsets, bit positions, reset values and frame counts of the mapper controls
`ifndef MCR_CFG_SVH
`define MCR_CFG_SVH

`define MCR_OFF_FMT       8'hc0
`define MCR_OFF_LOOP      8'hc1
`define MCR_OFF_ALARM     8'hc2
`define MCR_OFF_SRC       8'hc3

`define MCR_RST_FMT       8'h00
`define MCR_RST_LOOP      8'h00
`define MCR_RST_ALARM     8'h00
`define MCR_RST_SRC       8'h00

`define MCR_B_FMT_HI      7
`define MCR_B_FMT_LO      6
`define MCR_B_DS3         0
`define MCR_B_FAC_LOOP    2
`define MCR_B_BUS_LOOP    0
`define MCR_B_ALM_AIS     7
`define MCR_B_ALM_NINE    6
`define MCR_B_LINE_AIS    5
`define MCR_B_PATH_AIS    4
`define MCR_B_ZERO_SPE    3
`define MCR_B_IRQ_FLT     2
`define MCR_B_ADD_FLT     1
`define MCR_B_RX_FLT      0

`define MCR_G1_NINE       4'h9
`define MCR_DS3_PAY_LAST  7'h54
`define MCR_DS3_BLK_LAST  3'h7
`define MCR_DS3_SUB_LAST  3'h6

`endif

// [pkg/mcr_pkg.sv]
// types shared by the mapper control block and its line AIS generator
package mcr_pkg;

  typedef enum logic [2:0] {
    POH_J1 = 3'h0,
    POH_C2 = 3'h1,
    POH_G1 = 3'h2,
    POH_F2 = 3'h3,
    POH_H4 = 3'h4,
    POH_Z3 = 3'h5,
    POH_Z4 = 3'h6,
    POH_Z5 = 3'h7
  } mcr_poh_t;

  typedef enum logic [1:0] {
    AIS_IDLE = 2'h0,
    AIS_OH   = 2'h1,
    AIS_PAY  = 2'h3
  } mcr_ais_st_t;

  typedef struct packed {
    mcr_ais_st_t st;
    logic [2:0]  sub;
    logic [2:0]  blk;
    logic [6:0]  pos;
    logic        par;
    logic        par_prev;
    logic        bit_out;
  } mcr_ais_state_t;

  typedef struct packed {
    logic [7:0] fmt;
    logic [7:0] loop;
    logic [7:0] alarm;
    logic [7:0] src;
    logic [7:0] rdata;
    logic [7:0] drop_byte;
    logic [7:0] poh_byte;
    logic [5:0] j1_idx;
    logic       line_bit;
    logic       rx_ais;
    logic       path_ais;
    logic       unequip;
    logic       sts1;
    logic       format_lo_bit;
    logic       format_hi_bit;
    logic       irq;
    logic       irq_oe;
    logic       add_oe;
    logic       add_ind;
    logic       add_tim_oe;
    logic       rx_oe;
  } mcr_ctrl_state_t;

endpackage

// [pkg/mcr_ais_if.sv]
// control and bit path between the control block and the line AIS generator
`timescale 1ns/1ps
`default_nettype none

interface mcr_ais_if;
  logic en;
  logic ds3;
  logic bit_en;
  logic ais_bit;

  modport gen (input en, input ds3, input bit_en, output ais_bit);
  modport ctl (output en, output ds3, output bit_en, input ais_bit);
endinterface

`default_nettype wire

// [hdl/mcr_ais_gen.sv]
// ds3 m-frame and e3 all-ones line AIS pattern generator
`timescale 1ns/1ps
`default_nettype none
`include "mcr_cfg.svh"

module mcr_ais_gen (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // control and pattern
  mcr_ais_if.gen    ais
);

  mcr_pkg::mcr_ais_state_t q;
  mcr_pkg::mcr_ais_state_t n;

  // overhead bit of a block: x, f1, c, f0, c, f0, c, f1
  function automatic logic oh_bit(input logic [2:0] sub, input logic [2:0] blk,
                                  input logic par_prev);
    logic r;
    r = 1'b0;
    if (blk == 3'h0)
    begin
      unique case (sub)
        3'h0, 3'h1: r = 1'b1;
        3'h2, 3'h3: r = par_prev;
        3'h5:       r = 1'b1;
        default:    r = 1'b0;
      endcase
    end
    else
      r = (blk == 3'h1) || (blk == 3'h7);
    return r;
  endfunction

  always_comb
  begin
    n = q;
    if (!ais.en)
    begin
      n.st      = mcr_pkg::AIS_IDLE;
      n.sub     = 3'h0;
      n.blk     = 3'h0;
      n.pos     = 7'h00;
      n.par     = 1'b0;
      n.bit_out = 1'b1;
    end
    else if (ais.bit_en)
    begin
      if (!ais.ds3)
        n.bit_out = 1'b1;
      else
      begin
        unique case (q.st)
          mcr_pkg::AIS_IDLE, mcr_pkg::AIS_OH:
          begin
            n.bit_out = oh_bit(q.sub, q.blk, q.par_prev);
            n.pos     = 7'h01;
            n.st      = mcr_pkg::AIS_PAY;
          end
          mcr_pkg::AIS_PAY:
          begin
            // payload restarts with a one after every overhead bit
            n.bit_out = q.pos[0];
            n.par     = q.par ^ q.pos[0];
            n.pos     = q.pos + 7'h01;
            if (q.pos == `MCR_DS3_PAY_LAST)
            begin
              n.pos = 7'h00;
              n.st  = mcr_pkg::AIS_OH;
              n.blk = q.blk + 3'h1;
              if (q.blk == `MCR_DS3_BLK_LAST)
              begin
                n.blk = 3'h0;
                n.sub = q.sub + 3'h1;
                if (q.sub == `MCR_DS3_SUB_LAST)
                begin
                  // p-bits of the next frame carry this frame's payload parity
                  n.sub      = 3'h0;
                  n.par_prev = q.par ^ q.pos[0];
                  n.par      = 1'b0;
                end
              end
            end
          end
          default: n.st = mcr_pkg::AIS_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      q <= '{st: mcr_pkg::AIS_IDLE, bit_out: 1'b1, default: '0};
    else
      q <= n;
  end

  assign ais.ais_bit = q.bit_out;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_e3_all_ones: assert property (ais.en && !ais.ds3 && ais.bit_en |=> ais.ais_bit)
    else $error("e3 ais bit not one");
  a_ds3_pay_alt: assert property (ais.en && ais.ds3 && ais.bit_en && q.st == mcr_pkg::AIS_PAY
    |=> ais.ais_bit == $past(q.pos[0]))
    else $error("ds3 ais payload not alternating");
  a_ds3_fbits: assert property (ais.en && ais.ds3 && ais.bit_en && q.st == mcr_pkg::AIS_OH
    && (q.blk == 3'h3 || q.blk == 3'h5) |=> !ais.ais_bit)
    else $error("ds3 ais f0 bit not zero");

endmodule

`default_nettype wire

// [hdl/mcr_ctrl.sv]
// microprocessor control registers of the ds3/e3 mapper and the logic they steer
//
// Function
// - bus loopback returns add signal as drop
// - selected alarm raises receive line AIS
// - selected alarm forces count nine in G1 from internal bits
// - line AIS toward bus, ignoring facility loopback
// - ds3 AIS: valid M-frame, 1010 payload
// - e3 AIS is continuous ones
// - path AIS (format field 3 only) or zero SPE transmitted
// - interrupt idle level driven or floated
// - add bus float, indicator high
// - receive line outputs float when selected
// - path bytes from port or RAM
// - G1 from port or internal bits
// - J1 from port or 64-entry RAM
// - bus format field decodes mapping type
`timescale 1ns/1ps
`default_nettype none
`include "mcr_cfg.svh"

module mcr_ctrl (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // microprocessor port
  input  wire logic [7:0]        up_addr,
  input  wire logic [7:0]        up_wdata,
  input  wire logic              up_wr,
  input  wire logic              up_rd,
  output logic      [7:0]        up_rdata,
  // mode leads
  input  wire logic              motorola_mode,
  input  wire logic              ext_timing,
  input  wire logic              count_nine_enable,
  input  wire logic              rx_ais_enable,
  input  wire logic              ext_alarm_lead_select,
  // alarm sources
  input  wire logic              e1_ais_in,
  input  wire logic              ext_status_in,
  input  wire logic              ext_path_ais_in,
  input  wire logic              irq_event,
  // sdh/sonet bus
  input  wire logic [7:0]        add_loop_byte,
  input  wire logic [7:0]        drop_bus_byte,
  input  wire logic              add_ind_in,
  output logic      [7:0]        drop_byte,
  output logic                   add_bus_oe,
  output logic                   add_ind,
  output logic                   add_timing_oe,
  // line side
  input  wire logic              tx_line_dat,
  input  wire logic              tx_bit_en,
  output logic                   tx_line_bit,
  output logic                   rx_line_ais,
  output logic                   rx_line_oe,
  // path overhead
  input  wire logic              poh_stb,
  input  wire mcr_pkg::mcr_poh_t poh_sel,
  input  wire logic [7:0]        poh_port_byte,
  input  wire logic [7:0]        poh_ram_byte,
  output logic      [7:0]        tx_poh_byte,
  output logic      [5:0]        j1_ram_idx,
  output logic                   path_ais_send,
  output logic                   unequip_send,
  // bus format
  output logic                   fmt_sts1,
  output logic                   fmt_format_lo_bit,
  output logic                   fmt_format_hi_bit,
  // interrupt lead
  output logic                   irq_out,
  output logic                   irq_oe
);

  mcr_pkg::mcr_ctrl_state_t q;
  mcr_pkg::mcr_ctrl_state_t n;

  mcr_ais_if ais ();

  logic alarm_src;
  logic nine_force;

  // a path byte comes from the external port when its select bit is set;
  // the byte code doubles as the bit index of the select register
  function automatic logic from_port(input logic [7:0] src, input mcr_pkg::mcr_poh_t sel);
    return src[sel];
  endfunction

  function automatic logic [7:0] reg_read(input mcr_pkg::mcr_ctrl_state_t s,
                                          input logic [7:0] addr);
    logic [7:0] r;
    r = 8'h00;
    unique case (addr)
      `MCR_OFF_FMT:   r = s.fmt;
      `MCR_OFF_LOOP:  r = s.loop;
      `MCR_OFF_ALARM: r = s.alarm;
      `MCR_OFF_SRC:   r = s.src;
      default:        r = 8'h00;
    endcase
    return r;
  endfunction

  assign ais.en     = q.alarm[`MCR_B_LINE_AIS];
  assign ais.ds3    = q.fmt[`MCR_B_DS3];
  assign ais.bit_en = tx_bit_en;

  mcr_ais_gen u_ais_gen (
    .mclk (mclk),
    .rst  (rst),
    .ais  (ais.gen)
  );

  // alarm chosen by the lead select feeds both the AIS and count-nine paths
  assign alarm_src  = ext_alarm_lead_select ? (ext_status_in | ext_path_ais_in) : e1_ais_in;
  assign nine_force = q.alarm[`MCR_B_ALM_NINE] & count_nine_enable & alarm_src;

  always_comb
  begin
    n = q;

    // full byte writes, held until rewritten or reset
    if (up_wr)
    begin
      unique case (up_addr)
        `MCR_OFF_FMT:   n.fmt   = up_wdata;
        `MCR_OFF_LOOP:  n.loop  = up_wdata;
        `MCR_OFF_ALARM: n.alarm = up_wdata;
        `MCR_OFF_SRC:   n.src   = up_wdata;
        default:        n.fmt   = q.fmt;
      endcase
    end
    if (up_rd)
      n.rdata = reg_read(q, up_addr);

    // drop side input is ignored while the bus loopback is on
    n.drop_byte = q.loop[`MCR_B_BUS_LOOP] ? add_loop_byte : drop_bus_byte;

    n.rx_ais = q.alarm[`MCR_B_ALM_AIS] & rx_ais_enable & alarm_src;

    // facility loopback bit has no say over transmitted line AIS
    n.line_bit = q.alarm[`MCR_B_LINE_AIS] ? ais.ais_bit : tx_line_dat;

    n.sts1 = (q.fmt[`MCR_B_FMT_HI:`MCR_B_FMT_LO] == 2'h0);
    n.format_lo_bit = (q.fmt[`MCR_B_FMT_HI:`MCR_B_FMT_LO] == 2'h1);
    n.format_hi_bit = (q.fmt[`MCR_B_FMT_HI:`MCR_B_FMT_LO] == 2'h3);

    n.unequip  = q.alarm[`MCR_B_PATH_AIS] & q.alarm[`MCR_B_ZERO_SPE];
    n.path_ais = q.alarm[`MCR_B_PATH_AIS] & ~q.alarm[`MCR_B_ZERO_SPE]
                 & (q.fmt[`MCR_B_FMT_HI:`MCR_B_FMT_LO] == 2'h3);

    // intel style is active high, motorola style active low
    n.irq    = motorola_mode ? ~irq_event : irq_event;
    n.irq_oe = irq_event | ~q.alarm[`MCR_B_IRQ_FLT];

    n.add_oe     = ~q.alarm[`MCR_B_ADD_FLT];
    n.add_ind    = q.alarm[`MCR_B_ADD_FLT] | add_ind_in;
    n.add_tim_oe = ~(q.alarm[`MCR_B_ADD_FLT] & ext_timing);

    n.rx_oe = ~q.alarm[`MCR_B_RX_FLT];

    if (poh_stb)
    begin
      if (from_port(q.src, poh_sel))
        n.poh_byte = poh_port_byte;
      else
      begin
        n.poh_byte = poh_ram_byte;
        if (poh_sel == mcr_pkg::POH_G1 && nine_force)
          n.poh_byte[7:4] = `MCR_G1_NINE;
        // j1 trace walks a 64-entry ram segment, wrapping on its own
        if (poh_sel == mcr_pkg::POH_J1)
          n.j1_idx = q.j1_idx + 6'h01;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      q <= '{fmt: `MCR_RST_FMT, loop: `MCR_RST_LOOP, alarm: `MCR_RST_ALARM,
             src: `MCR_RST_SRC, sts1: 1'b1, irq_oe: 1'b1, add_oe: 1'b1,
             add_ind: 1'b1, add_tim_oe: 1'b1, rx_oe: 1'b1, line_bit: 1'b0,
             default: '0};
    else
      q <= n;
  end

  assign up_rdata      = q.rdata;
  assign drop_byte     = q.drop_byte;
  assign add_bus_oe    = q.add_oe;
  assign add_ind       = q.add_ind;
  assign add_timing_oe = q.add_tim_oe;
  assign tx_line_bit   = q.line_bit;
  assign rx_line_ais   = q.rx_ais;
  assign rx_line_oe    = q.rx_oe;
  assign tx_poh_byte   = q.poh_byte;
  assign j1_ram_idx    = q.j1_idx;
  assign path_ais_send = q.path_ais;
  assign unequip_send  = q.unequip;
  assign fmt_sts1      = q.sts1;
  assign fmt_format_lo_bit      = q.format_lo_bit;
  assign fmt_format_hi_bit      = q.format_hi_bit;
  assign irq_out       = q.irq;
  assign irq_oe        = q.irq_oe;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_bus_loop_mux: assert property (q.loop[`MCR_B_BUS_LOOP] && !up_wr
    |=> drop_byte == $past(add_loop_byte))
    else $error("loopback drop byte not the add byte");

  a_rx_ais_gen: assert property (q.alarm[`MCR_B_ALM_AIS] && rx_ais_enable &&
    !ext_alarm_lead_select && e1_ais_in |=> rx_line_ais)
    else $error("receive line ais missing on e1 ais");

  a_nine_force: assert property (poh_stb && poh_sel == mcr_pkg::POH_G1 &&
    !q.src[2] && nine_force |=> tx_poh_byte[7:4] == 4'h9)
    else $error("g1 count of nine not forced");

  a_line_ais_sel: assert property (q.alarm[`MCR_B_LINE_AIS] && $stable(q.alarm)
    |=> tx_line_bit == $past(ais.ais_bit))
    else $error("line ais not sent toward bus");

  a_path_ais_out: assert property (q.alarm[4:3] == 2'h2 && q.fmt[7:6] == 2'h3
    && $stable(q.alarm) && $stable(q.fmt) |=> path_ais_send && !unequip_send)
    else $error("tug-3 path ais not sent");

  a_irq_idle_drive: assert property (!irq_event && !q.alarm[`MCR_B_IRQ_FLT]
    |=> irq_oe && irq_out == $past(motorola_mode))
    else $error("interrupt idle level not driven");

  a_add_float: assert property (q.alarm[`MCR_B_ADD_FLT] && ext_timing
    |=> !add_bus_oe && add_ind && !add_timing_oe)
    else $error("add bus not floated");

  a_rx_float: assert property ($rose(q.alarm[`MCR_B_RX_FLT]) |=> !rx_line_oe)
    else $error("receive line outputs not floated");

  a_poh_port_src: assert property (poh_stb && q.src[poh_sel]
    |=> tx_poh_byte == $past(poh_port_byte))
    else $error("port overhead byte not selected");

  a_fmt_reserved: assert property (q.fmt[7:6] == 2'h2 && $stable(q.fmt)
    |=> !fmt_sts1 && !fmt_format_lo_bit && !fmt_format_hi_bit)
    else $error("reserved format decoded");

endmodule

`default_nettype wire

// [dv/mcr_bus_model.sv]
// drop bus and external overhead port model facing the mapper controls
`timescale 1ns/1ps
`default_nettype none
module mcr_bus_model #(
  parameter logic [7:0] DROP_VAL = 8'h3c,
  parameter logic [7:0] PORT_VAL = 8'hc5
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // bus side
  output logic      [7:0] drop_bus_byte,
  output logic      [7:0] poh_port_byte
);
  // bytes are re-driven every cycle so a stale value can never pass
  always_ff @(posedge mclk)
  begin
    drop_bus_byte <= rst ? 8'h00 : DROP_VAL;
    poh_port_byte <= rst ? 8'h00 : PORT_VAL;
  end
endmodule
`default_nettype wire

// [dv/mcr_ctrl_tb.sv]
// self-checking bench of the mapper control registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
  $display("BAD t=%0t got %h exp %h", $time, a, e); end end
module mcr_ctrl_tb;
  logic mclk, rst, up_wr, up_rd, motorola_mode, ext_timing, count_nine_enable;
  logic rx_ais_enable, ext_alarm_lead_select, e1_ais_in, ext_status_in;
  logic ext_path_ais_in, irq_event, add_ind_in, tx_line_dat, tx_bit_en, poh_stb;
  logic [7:0] up_addr, up_wdata, up_rdata, add_loop_byte, drop_bus_byte;
  logic [7:0] drop_byte, poh_port_byte, poh_ram_byte, tx_poh_byte;
  logic [5:0] j1_ram_idx;
  logic add_bus_oe, add_ind, add_timing_oe, tx_line_bit, rx_line_ais, rx_line_oe;
  logic path_ais_send, unequip_send, fmt_sts1, fmt_format_lo_bit, fmt_format_hi_bit, irq_out, irq_oe;
  mcr_pkg::mcr_poh_t poh_sel;
  int bad_count;
  int comparisons;

  mcr_ctrl i_mcr_ctrl (
    .mclk(mclk), .rst(rst), .up_addr(up_addr), .up_wdata(up_wdata),
    .up_wr(up_wr), .up_rd(up_rd), .up_rdata(up_rdata),
    .motorola_mode(motorola_mode), .ext_timing(ext_timing),
    .count_nine_enable(count_nine_enable), .rx_ais_enable(rx_ais_enable),
    .ext_alarm_lead_select(ext_alarm_lead_select), .e1_ais_in(e1_ais_in),
    .ext_status_in(ext_status_in), .ext_path_ais_in(ext_path_ais_in),
    .irq_event(irq_event), .add_loop_byte(add_loop_byte),
    .drop_bus_byte(drop_bus_byte), .add_ind_in(add_ind_in),
    .drop_byte(drop_byte), .add_bus_oe(add_bus_oe), .add_ind(add_ind),
    .add_timing_oe(add_timing_oe), .tx_line_dat(tx_line_dat),
    .tx_bit_en(tx_bit_en), .tx_line_bit(tx_line_bit), .rx_line_ais(rx_line_ais),
    .rx_line_oe(rx_line_oe), .poh_stb(poh_stb), .poh_sel(poh_sel),
    .poh_port_byte(poh_port_byte), .poh_ram_byte(poh_ram_byte),
    .tx_poh_byte(tx_poh_byte), .j1_ram_idx(j1_ram_idx),
    .path_ais_send(path_ais_send), .unequip_send(unequip_send),
    .fmt_sts1(fmt_sts1), .fmt_format_lo_bit(fmt_format_lo_bit), .fmt_format_hi_bit(fmt_format_hi_bit),
    .irq_out(irq_out), .irq_oe(irq_oe)
  );

  mcr_bus_model i_mcr_bus_model (
    .mclk(mclk), .rst(rst), .drop_bus_byte(drop_bus_byte),
    .poh_port_byte(poh_port_byte)
  );

  task automatic settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  // full-byte host write, returns once derived outputs have settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    up_addr <= a;
    up_wdata <= d;
    up_wr <= 1'b1;
    @(posedge mclk);
    up_wr <= 1'b0;
    settle;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    up_addr <= a;
    up_rd <= 1'b1;
    @(posedge mclk);
    up_rd <= 1'b0;
    #1;
    `CHK(up_rdata, e)
  endtask

  task automatic poh(input mcr_pkg::mcr_poh_t s, input logic [7:0] e);
    @(posedge mclk);
    poh_sel <= s;
    poh_stb <= 1'b1;
    @(posedge mclk);
    poh_stb <= 1'b0;
    #1;
    `CHK(tx_poh_byte, e)
  endtask

  task automatic lbit(input logic e);
    @(posedge mclk);
    tx_bit_en <= 1'b1;
    @(posedge mclk);
    tx_bit_en <= 1'b0;
    settle;
    `CHK(tx_line_bit, e)
  endtask

  task automatic t_regs;
    rd_chk(8'hc1, 8'h00);
    rd_chk(8'hc2, 8'h00);
    rd_chk(8'hc3, 8'h00);
    `CHK({fmt_sts1, add_bus_oe, add_ind, rx_line_oe, irq_out}, 5'h1a)
    wr(8'hc1, 8'ha4);
    wr(8'hc3, 8'h5a);
    wr(8'hc5, 8'hff);
    rd_chk(8'hc1, 8'ha4);
    rd_chk(8'hc3, 8'h5a);
    rd_chk(8'hc5, 8'h00);
    wr(8'hc1, 8'h00);
    wr(8'hc3, 8'h00);
    $display("test regs done");
  endtask

  task automatic t_loop;
    @(posedge mclk);
    add_loop_byte <= 8'h96;
    wr(8'hc1, 8'h01);
    `CHK({drop_byte, add_bus_oe}, 9'h12d)
    wr(8'hc1, 8'h00);
    `CHK(drop_byte, 8'h3c)
    $display("test loop done");
  endtask

  task automatic t_fmt;
    logic [7:0] v [4] = '{8'h00, 8'h40, 8'h80, 8'hc0};
    logic [2:0] e [4] = '{3'h4, 3'h2, 3'h0, 3'h1};
    for (int i = 0; i < 4; i++)
    begin
      wr(8'hc0, v[i]);
      `CHK({fmt_sts1, fmt_format_lo_bit, fmt_format_hi_bit}, e[i])
    end
    wr(8'hc2, 8'h10);
    `CHK({path_ais_send, unequip_send}, 2'h2)
    wr(8'hc2, 8'h18);
    `CHK({path_ais_send, unequip_send}, 2'h1)
    wr(8'hc2, 8'h08);
    `CHK({path_ais_send, unequip_send}, 2'h0)
    $display("test format done");
  endtask

  task automatic t_alarm;
    @(posedge mclk);
    rx_ais_enable <= 1'b1;
    e1_ais_in <= 1'b1;
    wr(8'hc2, 8'h80);
    `CHK(rx_line_ais, 1'b1)
    @(posedge mclk);
    ext_alarm_lead_select <= 1'b1;
    settle;
    `CHK(rx_line_ais, 1'b0)
    @(posedge mclk);
    ext_path_ais_in <= 1'b1;
    settle;
    `CHK(rx_line_ais, 1'b1)
    @(posedge mclk);
    ext_path_ais_in <= 1'b0;
    ext_status_in <= 1'b1;
    settle;
    `CHK(rx_line_ais, 1'b1)
    @(posedge mclk);
    rx_ais_enable <= 1'b0;
    count_nine_enable <= 1'b1;
    poh_ram_byte <= 8'h05;
    settle;
    `CHK(rx_line_ais, 1'b0)
    wr(8'hc2, 8'h40);
    poh(mcr_pkg::POH_G1, 8'h95);
    wr(8'hc3, 8'h04);
    poh(mcr_pkg::POH_G1, 8'hc5);
    wr(8'hc3, 8'h00);
    wr(8'hc2, 8'h00);
    poh(mcr_pkg::POH_G1, 8'h05);
    $display("test alarm done");
  endtask

  task automatic t_poh;
    for (int i = 1; i < 8; i++)
    begin
      wr(8'hc3, 8'h01 << i);
      poh(mcr_pkg::mcr_poh_t'(3'(i)), 8'hc5);
      wr(8'hc3, 8'h00);
      poh(mcr_pkg::mcr_poh_t'(3'(i)), 8'h05);
    end
    poh(mcr_pkg::POH_J1, 8'h05);
    `CHK(j1_ram_idx, 6'h01)
    for (int i = 0; i < 63; i++)
      poh(mcr_pkg::POH_J1, 8'h05);
    `CHK(j1_ram_idx, 6'h00)
    wr(8'hc3, 8'h01);
    poh(mcr_pkg::POH_J1, 8'hc5);
    `CHK(j1_ram_idx, 6'h00)
    wr(8'hc3, 8'h00);
    $display("test overhead done");
  endtask

  task automatic t_line;
    logic [7:0] oh = 8'h83;
    wr(8'hc1, 8'h04);
    wr(8'hc2, 8'h20);
    for (int i = 0; i < 8; i++)
      lbit(1'b1);
    wr(8'hc2, 8'h00);
    lbit(1'b0);
    wr(8'hc0, 8'hc1);
    wr(8'hc2, 8'h20);
    for (int b = 0; b < 8; b++)
    begin
      lbit(oh[b]);
      for (int k = 0; k < 84; k++)
        lbit(~k[0]);
    end
    wr(8'hc2, 8'h00);
    wr(8'hc1, 8'h00);
    $display("test line done");
  endtask

  task automatic t_float;
    @(posedge mclk);
    ext_timing <= 1'b1;
    wr(8'hc2, 8'h04);
    `CHK(irq_oe, 1'b0)
    @(posedge mclk);
    irq_event <= 1'b1;
    settle;
    `CHK({irq_oe, irq_out}, 2'h3)
    @(posedge mclk);
    irq_event <= 1'b0;
    motorola_mode <= 1'b1;
    add_ind_in <= 1'b1;
    wr(8'hc2, 8'h00);
    `CHK({irq_oe, irq_out, add_ind}, 3'h7)
    @(posedge mclk);
    add_ind_in <= 1'b0;
    wr(8'hc2, 8'h03);
    `CHK({add_bus_oe, add_ind, add_timing_oe, rx_line_oe}, 4'h4)
    @(posedge mclk);
    ext_timing <= 1'b0;
    settle;
    `CHK(add_timing_oe, 1'b1)
    $display("test float done");
  endtask

  task automatic test_done;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial
  begin
    {rst, up_wr, up_rd, motorola_mode, ext_timing, count_nine_enable} = 6'h20;
    {rx_ais_enable, ext_alarm_lead_select, e1_ais_in, ext_status_in} = 4'h0;
    {ext_path_ais_in, irq_event, add_ind_in, tx_line_dat, tx_bit_en} = 5'h00;
    {up_addr, up_wdata, add_loop_byte, poh_ram_byte} = 32'h0000_0000;
    poh_stb = 1'b0;
    poh_sel = mcr_pkg::POH_J1;
    bad_count = 0;
    comparisons = 0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    t_regs;
    t_loop;
    t_fmt;
    t_alarm;
    t_poh;
    t_line;
    t_float;
    test_done;
  end

  // the line test dominates, about three thousand cycles in all
  initial
  begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    $display("BAD t=%0t watchdog", $time);
    test_done;
  end
endmodule
`default_nettype wire
